// *** rtl/irq_level_pkg.sv ***
// Constants for the IRQ level and priority control block.
// Assumes an APB slave with 32-bit data and byte addresses.
package irq_level_pkg;

  // ******************************************************************
  // Register byte addresses
  // ******************************************************************
  localparam logic [31:0] ADDR_SOURCE_NUMBER    = 32'h7800_0014;
  localparam logic [31:0] ADDR_IN_SERVICE       = 32'h7800_0018;
  localparam logic [31:0] ADDR_LEVEL_CTRL_HI    = 32'h7800_0024;
  localparam logic [31:0] ADDR_LEVEL_CLEAR      = 32'h7800_0028;
  localparam logic [31:0] ADDR_LEVEL_ENCODE     = 32'h7800_002C;
  localparam logic [31:0] ADDR_EDGE_CLEAR_NUM   = 32'h7BF0_0004;
  localparam logic [31:0] ADDR_UPPER_REQ_STATUS = 32'h7BF0_0010;
  localparam logic [31:0] ADDR_DETECT_MODE      = 32'h7BF0_0014;
  localparam logic [31:0] ADDR_UPPER_LEVEL_CTRL = 32'h7BF0_0018;
  localparam logic [31:0] ADDR_EVT_STATUS       = 32'h7BF0_0040;
  localparam logic [31:0] ADDR_EVT_ENABLE       = 32'h7BF0_0044;
  localparam logic [31:0] ADDR_EVT_CLEAR        = 32'h7BF0_0048;

  // ******************************************************************
  // Field layout
  // ******************************************************************
  localparam int LEVEL_W      = 3;   // Width of one level field
  localparam int LEVEL_STRIDE = 4;   // Bit stride between level fields
  localparam int MODE_STRIDE  = 2;   // Bit stride between detect mode bits
  localparam int SRC_NUM_W    = 7;   // Source number field width
  localparam int FIRST_SRC    = 8;   // Lowest source handled here
  localparam int FIRST_UPPER  = 16;  // Lowest edge-capable source
  localparam int NUM_SRC      = 24;  // Sources 8 to 31
  localparam int NUM_UPPER    = 16;  // Sources 16 to 31
  localparam int IN_SVC_W     = 8;   // In-service bits 7:1, bit 0 unused
  localparam int EVT_W        = 2;   // Event status width
  localparam int EVT_NOTIFY   = 0;   // New IRQ notification raised
  localparam int EVT_EDGE     = 1;   // Edge request captured

  // ******************************************************************
  // Write masks and reset values
  // ******************************************************************
  localparam logic [31:0] LEVEL_FIELDS_MASK = 32'h7777_7777;
  localparam logic [31:0] MODE_BITS_MASK    = 32'h0000_5555;
  localparam logic [31:0] LEVEL_CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] DETECT_MODE_RESET = 32'h0000_0000;
  localparam logic [7:0]  IN_SVC_RESET      = 8'h00;
  localparam logic [1:0]  EVT_RESET         = 2'h0;
  localparam logic [2:0]  LEVEL_MASKED      = 3'h0;

endpackage

// *** rtl/irq_level_ctrl.sv ***
// IRQ level and priority control for sources 8 to 31, APB slave.
// Assumes request inputs are asynchronous and active low.
//
// What this block does
// - Three-bit level per source 8-15, 000 masks
// - Reserved bits read zero; software writes zero
// - Strobe write clears highest in-service bit only
// - Encode register returns highest in-service index
// - Number clear drops edge request, level ignored
// - Upper status shows sources 16-31 pending
// - Write one clears edge-mode status bits only
// - Level mode: input low and level nonzero
// - Raw request flag follows input, ignores level
// - Falling edge sets sticky request until cleared
// - Mode bit per pair, even bits, reset zero
// - Mode bit zero level, one edge detection
// - Source number read sets in-service bit
// - Withhold requests at or below highest in-service level
`timescale 1ns/1ps

module irq_level_ctrl (
  // Clock and reset
  input  wire logic                                      pclk,
  input  wire logic                                      presetn,
  // APB slave
  input  wire logic                                      psel,
  input  wire logic                                      penable,
  input  wire logic                                      pwrite,
  input  wire logic [31:0]                               paddr,
  input  wire logic [31:0]                               pwdata,
  output logic      [31:0]                               prdata,
  output logic                                           pready,
  output logic                                           pslverr,
  // Request inputs for sources 8 to 31, active low
  input  wire logic [irq_level_pkg::NUM_SRC-1:0]         request_inputs_n,
  // IRQ request to the core and event interrupt
  output logic                                           irq_req,
  output logic                                           evt_irq
);

  localparam int NS = irq_level_pkg::NUM_SRC;
  localparam int NU = irq_level_pkg::NUM_UPPER;
  localparam int LW = irq_level_pkg::LEVEL_W;
  localparam int LS = irq_level_pkg::LEVEL_STRIDE;

  // ******************************************************************
  // APB access phase, one wait state
  // ******************************************************************
  logic              pready_q;
  logic [31:0]       prdata_q;
  logic              pslverr_q;
  logic              acc_first;
  logic              acc_done;
  logic              wr_done;
  logic              rd_done;
  logic              hit;
  logic [31:0]       rd_d;

  assign acc_first = psel & penable & ~pready_q;
  assign acc_done  = psel & penable & pready_q;
  assign wr_done   = acc_done & pwrite;
  assign rd_done   = acc_done & ~pwrite;
  assign pready    = pready_q;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q;

  // ******************************************************************
  // Register state
  // ******************************************************************
  logic [31:0]                           lvl_ctrl_q;
  logic [31:0]                           upper_lvl_q;
  logic [31:0]                           mode_q;
  logic [irq_level_pkg::IN_SVC_W-1:0]    in_svc_q;
  logic [irq_level_pkg::EVT_W-1:0]       evt_sts_q;
  logic [irq_level_pkg::EVT_W-1:0]       evt_en_q;
  logic [NS-1:0]                         sync1_q;
  logic [NS-1:0]                         sync2_q;
  logic [NS-1:0]                         prev_q;
  logic [NU-1:0]                         edge_q;
  logic [irq_level_pkg::SRC_NUM_W-1:0]   best_num_q;
  logic [LW-1:0]                         best_lvl_q;
  logic                                  irq_req_q;

  // ******************************************************************
  // Per-source level, raw flag, mode and visible status
  // ******************************************************************
  logic [LW-1:0] src_lvl [NS];
  logic [NS-1:0] raw_req;
  logic [NS-1:0] pend;
  logic [NU-1:0] edge_mode;
  logic [NU-1:0] upper_sts;
  logic [NU-1:0] edge_set;
  logic [NU-1:0] edge_clr;
  logic          wr_num_clr;
  logic          wr_sts_clr;

  assign wr_num_clr = wr_done & (paddr == irq_level_pkg::ADDR_EDGE_CLEAR_NUM);
  assign wr_sts_clr = wr_done & (paddr == irq_level_pkg::ADDR_UPPER_REQ_STATUS);

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_src
      // Raw flag tracks the synchronised pin only
      assign raw_req[gi] = ~sync2_q[gi];
      if (gi < 8) begin : g_lo
        assign src_lvl[gi] = lvl_ctrl_q[LS*gi +: LW];
        assign pend[gi]    = raw_req[gi] & (src_lvl[gi] != irq_level_pkg::LEVEL_MASKED);
      end else begin : g_up
        localparam int U = gi - 8;
        assign src_lvl[gi]  = upper_lvl_q[LS*(U/2) +: LW];
        assign edge_mode[U] = mode_q[irq_level_pkg::MODE_STRIDE*(U/2)];
        // Level mode view, else the sticky edge bit
        assign upper_sts[U] = edge_mode[U] ? edge_q[U] :
                              raw_req[gi] & (src_lvl[gi] != irq_level_pkg::LEVEL_MASKED);
        assign pend[gi]     = upper_sts[U] & (src_lvl[gi] != irq_level_pkg::LEVEL_MASKED);
        // High-to-low transition in edge mode
        assign edge_set[U]  = edge_mode[U] & prev_q[gi] & ~sync2_q[gi];
        // Clears by status write or by number, edge mode only
        assign edge_clr[U]  = edge_mode[U] &
          ((wr_sts_clr & pwdata[U]) |
           (wr_num_clr & (pwdata[irq_level_pkg::SRC_NUM_W-1:0] ==
                          7'(irq_level_pkg::FIRST_UPPER + U))));
      end
    end
  endgenerate

  // Two-stage synchroniser, then a delayed copy for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '1;
      sync2_q <= '1;
      prev_q  <= '1;
    end else begin
      sync1_q <= request_inputs_n;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Sticky edge requests, a new edge wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_q <= '0;
    end else begin
      edge_q <= (edge_q & ~edge_clr) | edge_set;
    end
  end

  // ******************************************************************
  // In-service level
  // ******************************************************************
  logic [LW-1:0]                        cur_lvl;
  logic [irq_level_pkg::IN_SVC_W-1:0]   top_mask;
  logic                                 rd_num;

  // Highest set in-service bit as a binary level
  always_comb begin
    cur_lvl  = '0;
    top_mask = '0;
    for (int k = 1; k < irq_level_pkg::IN_SVC_W; k++) begin
      if (in_svc_q[k]) begin
        cur_lvl  = LW'(k);
        top_mask = irq_level_pkg::IN_SVC_W'(1) << k;
      end
    end
  end

  assign rd_num = rd_done & (paddr == irq_level_pkg::ADDR_SOURCE_NUMBER);

  // Set on source number read, cleared by strobe or write-one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_svc_q <= irq_level_pkg::IN_SVC_RESET;
    end else if (rd_num && irq_req_q) begin
      in_svc_q[best_lvl_q] <= 1'b1;
    end else if (wr_done && paddr == irq_level_pkg::ADDR_LEVEL_CLEAR) begin
      in_svc_q <= in_svc_q & ~top_mask;
    end else if (wr_done && paddr == irq_level_pkg::ADDR_IN_SERVICE) begin
      in_svc_q <= in_svc_q & ~{pwdata[7:1], 1'b0};
    end
  end

  // ******************************************************************
  // Priority arbitration
  // ******************************************************************
  logic [LW-1:0]                       arb_lvl;
  logic [irq_level_pkg::SRC_NUM_W-1:0] arb_num;

  // Strictly greater keeps the lowest number on ties
  always_comb begin
    arb_lvl = '0;
    arb_num = '0;
    for (int k = 0; k < NS; k++) begin
      if (pend[k] && src_lvl[k] > arb_lvl) begin
        arb_lvl = src_lvl[k];
        arb_num = 7'(irq_level_pkg::FIRST_SRC + k);
      end
    end
  end

  // Registered winner, held back at or below the active level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      best_lvl_q <= '0;
      best_num_q <= '0;
      irq_req_q  <= 1'b0;
    end else begin
      best_lvl_q <= arb_lvl;
      best_num_q <= arb_num;
      irq_req_q  <= (arb_lvl > cur_lvl);
    end
  end

  assign irq_req = irq_req_q;

  // ******************************************************************
  // Control registers
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_ctrl_q  <= irq_level_pkg::LEVEL_CTRL_RESET;
      upper_lvl_q <= irq_level_pkg::LEVEL_CTRL_RESET;
      mode_q      <= irq_level_pkg::DETECT_MODE_RESET;
      evt_en_q    <= irq_level_pkg::EVT_RESET;
    end else if (wr_done) begin
      case (paddr)
        irq_level_pkg::ADDR_LEVEL_CTRL_HI:
          lvl_ctrl_q <= pwdata & irq_level_pkg::LEVEL_FIELDS_MASK;
        irq_level_pkg::ADDR_UPPER_LEVEL_CTRL:
          upper_lvl_q <= pwdata & irq_level_pkg::LEVEL_FIELDS_MASK;
        irq_level_pkg::ADDR_DETECT_MODE:
          mode_q <= pwdata & irq_level_pkg::MODE_BITS_MASK;
        irq_level_pkg::ADDR_EVT_ENABLE:
          evt_en_q <= pwdata[irq_level_pkg::EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // ******************************************************************
  // Event status, enable and interrupt
  // ******************************************************************
  logic [irq_level_pkg::EVT_W-1:0] evt_set;
  logic [irq_level_pkg::EVT_W-1:0] evt_clr;
  logic                            irq_req_prev_q;

  assign evt_set[irq_level_pkg::EVT_NOTIFY] = irq_req_q & ~irq_req_prev_q;
  assign evt_set[irq_level_pkg::EVT_EDGE]   = |edge_set;
  assign evt_clr = (wr_done && paddr == irq_level_pkg::ADDR_EVT_CLEAR) ?
                   pwdata[irq_level_pkg::EVT_W-1:0] : '0;

  // Sticky events, a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_sts_q      <= irq_level_pkg::EVT_RESET;
      irq_req_prev_q <= 1'b0;
    end else begin
      evt_sts_q      <= (evt_sts_q & ~evt_clr) | evt_set;
      irq_req_prev_q <= irq_req_q;
    end
  end

  assign evt_irq = |(evt_sts_q & evt_en_q);

  // ******************************************************************
  // Read mux and APB answer
  // ******************************************************************
  always_comb begin
    rd_d = '0;
    hit  = 1'b1;
    case (paddr)
      irq_level_pkg::ADDR_SOURCE_NUMBER:    rd_d = 32'(best_num_q);
      irq_level_pkg::ADDR_IN_SERVICE:       rd_d = 32'(in_svc_q);
      irq_level_pkg::ADDR_LEVEL_CTRL_HI:    rd_d = lvl_ctrl_q;
      irq_level_pkg::ADDR_LEVEL_CLEAR:      rd_d = '0;
      irq_level_pkg::ADDR_LEVEL_ENCODE:     rd_d = 32'(cur_lvl);
      irq_level_pkg::ADDR_EDGE_CLEAR_NUM:   rd_d = '0;
      irq_level_pkg::ADDR_UPPER_REQ_STATUS: rd_d = 32'(upper_sts);
      irq_level_pkg::ADDR_DETECT_MODE:      rd_d = mode_q;
      irq_level_pkg::ADDR_UPPER_LEVEL_CTRL: rd_d = upper_lvl_q;
      irq_level_pkg::ADDR_EVT_STATUS:       rd_d = 32'(evt_sts_q);
      irq_level_pkg::ADDR_EVT_ENABLE:       rd_d = 32'(evt_en_q);
      irq_level_pkg::ADDR_EVT_CLEAR:        rd_d = '0;
      default:                              hit  = 1'b0;
    endcase
  end

  // Answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc_first;
      prdata_q  <= acc_first ? rd_d : '0;
      pslverr_q <= acc_first & ~hit;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  sequence s_strobe_wr;
    wr_done && paddr == irq_level_pkg::ADDR_LEVEL_CLEAR && !rd_num;
  endsequence

  sequence s_num_rd;
    rd_num && irq_req_q;
  endsequence

  property p_strobe_top_only;
    @(posedge pclk) disable iff (!presetn)
    s_strobe_wr |=> in_svc_q == ($past(in_svc_q) & ~$past(top_mask));
  endproperty
  a_strobe_top_only: assert property (p_strobe_top_only) else $error("strobe clear wrong");

  property p_encode_drops;
    @(posedge pclk) disable iff (!presetn)
    s_strobe_wr ##0 (cur_lvl != 3'h0) |=> cur_lvl < $past(cur_lvl);
  endproperty
  a_encode_drops: assert property (p_encode_drops) else $error("encode did not drop");

  property p_num_read_sets;
    @(posedge pclk) disable iff (!presetn)
    s_num_rd |=> in_svc_q[$past(best_lvl_q)] && cur_lvl >= $past(best_lvl_q);
  endproperty
  a_num_read_sets: assert property (p_num_read_sets) else $error("in-service not set");

  property p_withhold;
    @(posedge pclk) disable iff (!presetn)
    irq_req_q |-> best_lvl_q > $past(cur_lvl);
  endproperty
  a_withhold: assert property (p_withhold) else $error("request not withheld");
  property p_edge_set;
    @(posedge pclk) disable iff (!presetn)
    edge_mode[1] && prev_q[9] && !sync2_q[9] |=> edge_q[1] [*2];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge not held");
  property p_edge_num_clear;
    @(posedge pclk) disable iff (!presetn)
    wr_num_clr && pwdata[6:0] == 7'h11 && edge_mode[1] && !edge_set[1] |=> !edge_q[1];
  endproperty
  a_edge_num_clear: assert property (p_edge_num_clear) else $error("number clear failed");
  property p_level_ignores_clear;
    @(posedge pclk) disable iff (!presetn)
    wr_sts_clr && !edge_mode[0] && raw_req[8] ##1 raw_req[8] && !edge_mode[0]
      |-> upper_sts[0] == (src_lvl[8] != 3'h0);
  endproperty
  a_level_ignores_clear: assert property (p_level_ignores_clear) else $error("level bit cleared");
  property p_tie_lowest;
    @(posedge pclk) disable iff (!presetn)
    !(|pend[3:0]) && pend[4] && pend[5] && src_lvl[4] == src_lvl[5] && arb_lvl == src_lvl[4]
      |=> best_num_q == 7'h0C;
  endproperty
  a_tie_lowest: assert property (p_tie_lowest) else $error("tie not lowest");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    acc_first |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing");

endmodule

// *** testbench/irq_core_model.sv ***
// Behavioural model of the processor core that takes IRQ requests.
// Assumes irq_req is a registered level in the pclk domain.
`timescale 1ns/1ps

module irq_core_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request from the controller
  input  wire logic irq_req,
  // Notifications seen so far
  output int        notify_count
);
  logic irq_seen_q;

  // Count each new notification, one per rising edge of the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_seen_q   <= 1'b0;
      notify_count <= 0;
    end else begin
      irq_seen_q <= irq_req;
      if (irq_req && !irq_seen_q) begin
        notify_count <= notify_count + 1;
      end
    end
  end
endmodule

// *** testbench/irq_level_ctrl_bench.sv ***
// Self-checking bench for the IRQ level and priority control block.
// Assumes the package, the design and the core model are compiled first.
`timescale 1ns/1ps

module irq_level_ctrl_bench;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } row_t;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [23:0] req_n;
  logic        irq_req;
  logic        evt_irq;
  int          notify_count;
  int          errors;
  int          checks;
  logic [31:0] rd;
  logic        err;
  row_t        rows [5];

  irq_level_ctrl u_irq_level_ctrl (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .request_inputs_n (req_n),
    .irq_req          (irq_req),
    .evt_irq          (evt_irq)
  );

  irq_core_model u_irq_core_model (
    .pclk         (pclk),
    .presetn      (presetn),
    .irq_req      (irq_req),
    .notify_count (notify_count)
  );

  // ****************************************************************
  // Clock and helpers
  // ****************************************************************
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  task automatic tally_and_finish();
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t saw %h wanted %h", $time, seen, exp);
    end
  endtask

  // APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      tally_and_finish();
    end
  endtask

  // Drive the pins, then allow synchroniser and register to follow
  task automatic pins(input logic [23:0] v);
    @(posedge pclk);
    req_n <= v;
    repeat (4) @(posedge pclk);
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_req !== lvl && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic settle();
    @(posedge pclk);
    #1;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    req_n   = 24'hFFFFFF;
    errors  = 0;
    checks  = 0;
    rows[0] = '{irq_level_pkg::ADDR_LEVEL_CTRL_HI, 32'h0FFFFFFF, 32'h07777777};
    rows[1] = '{irq_level_pkg::ADDR_DETECT_MODE, 32'hFFFFFFFF, 32'h00005555};
    rows[2] = '{irq_level_pkg::ADDR_DETECT_MODE, 32'h00000000, 32'h00000000};
    rows[3] = '{irq_level_pkg::ADDR_LEVEL_ENCODE, 32'h00000007, 32'h00000000};
    rows[4] = '{irq_level_pkg::ADDR_LEVEL_CTRL_HI, 32'h00441073, 32'h00441073};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check(32'(irq_req), 32'h0);
    check(32'(evt_irq), 32'h0);
    apb(1'b0, irq_level_pkg::ADDR_LEVEL_CTRL_HI, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, irq_level_pkg::ADDR_DETECT_MODE, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, irq_level_pkg::ADDR_LEVEL_ENCODE, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 32'h7800_0030, 32'h0);
    check({rd[30:0], err}, 32'h1);
    // Write then read back each row; source 15 field kept at zero
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, rows[i].addr, rows[i].wdata);
      apb(1'b0, rows[i].addr, 32'h0);
      check(rd, rows[i].exp);
    end
    // Tie at level 4, then a higher and a lower source
    pins(24'hFFFFCF);
    wait_irq(1'b1);
    apb(1'b0, irq_level_pkg::ADDR_SOURCE_NUMBER, 32'h0);
    check(rd, 32'd12);
    wait_irq(1'b0);
    apb(1'b0, irq_level_pkg::ADDR_LEVEL_ENCODE, 32'h0);
    check(rd, 32'h4);
    pins(24'hFFFFCD);
    wait_irq(1'b1);
    apb(1'b0, irq_level_pkg::ADDR_SOURCE_NUMBER, 32'h0);
    check(rd, 32'd9);
    apb(1'b0, irq_level_pkg::ADDR_LEVEL_ENCODE, 32'h0);
    check(rd, 32'h7);
    pins(24'hFFFFF7);
    repeat (10) @(posedge pclk);
    check(32'(irq_req), 32'h0);
    apb(1'b1, irq_level_pkg::ADDR_LEVEL_CLEAR, 32'hFFFFFFFF);
    apb(1'b0, irq_level_pkg::ADDR_LEVEL_ENCODE, 32'h0);
    check(rd, 32'h4);
    check(32'(irq_req), 32'h0);
    apb(1'b1, irq_level_pkg::ADDR_LEVEL_CLEAR, 32'h0);
    apb(1'b0, irq_level_pkg::ADDR_LEVEL_ENCODE, 32'h0);
    check(rd, 32'h0);
    wait_irq(1'b1);
    apb(1'b0, irq_level_pkg::ADDR_SOURCE_NUMBER, 32'h0);
    check(rd, 32'd11);
    pins(24'hFFFFFF);
    apb(1'b1, irq_level_pkg::ADDR_LEVEL_CLEAR, 32'h5A5A5A5A);
    apb(1'b0, irq_level_pkg::ADDR_LEVEL_ENCODE, 32'h0);
    check(rd, 32'h0);
    check(32'(notify_count), 32'd3);
    // Level mode on sources 16 and 18
    pins(24'hFFFEFF);
    apb(1'b0, irq_level_pkg::ADDR_UPPER_REQ_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, irq_level_pkg::ADDR_UPPER_LEVEL_CTRL, 32'h00000022);
    apb(1'b0, irq_level_pkg::ADDR_UPPER_REQ_STATUS, 32'h0);
    check(rd, 32'h1);
    pins(24'hFFFAFF);
    apb(1'b1, irq_level_pkg::ADDR_UPPER_REQ_STATUS, 32'h0000FFFF);
    apb(1'b1, irq_level_pkg::ADDR_EDGE_CLEAR_NUM, 32'd18);
    apb(1'b0, irq_level_pkg::ADDR_UPPER_REQ_STATUS, 32'h0);
    check(rd, 32'h5);
    pins(24'hFFFFFF);
    apb(1'b0, irq_level_pkg::ADDR_UPPER_REQ_STATUS, 32'h0);
    check(rd, 32'h0);
    // Edge mode on the pair 16 and 17; its edges also set the edge event checked below
    apb(1'b1, irq_level_pkg::ADDR_DETECT_MODE, 32'h1);
    for (int k = 0; k < 2; k++) begin
      pins(24'hFFFDFF);
      pins(24'hFFFFFF);
      apb(1'b1, irq_level_pkg::ADDR_UPPER_REQ_STATUS, 32'h1);
      apb(1'b0, irq_level_pkg::ADDR_UPPER_REQ_STATUS, 32'h0);
      check(rd, 32'h2);
      if (k == 0) apb(1'b1, irq_level_pkg::ADDR_UPPER_REQ_STATUS, 32'h2);
      else apb(1'b1, irq_level_pkg::ADDR_EDGE_CLEAR_NUM, 32'd17);
      apb(1'b0, irq_level_pkg::ADDR_UPPER_REQ_STATUS, 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b1, irq_level_pkg::ADDR_DETECT_MODE, 32'h0);
    // Event interrupt: masked, enabled, cleared
    settle();
    check(32'(evt_irq), 32'h0);
    apb(1'b1, irq_level_pkg::ADDR_EVT_ENABLE, 32'h2);
    settle();
    check(32'(evt_irq), 32'h1);
    apb(1'b1, irq_level_pkg::ADDR_EVT_CLEAR, 32'h2);
    settle();
    check(32'(evt_irq), 32'h0);
    apb(1'b0, irq_level_pkg::ADDR_EVT_STATUS, 32'h0);
    check(rd & 32'h3, 32'h1);
    // Mid-run reset while source 11 requests
    pins(24'hFFFFF7);
    check(32'(irq_req), 32'h1);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check(32'(irq_req), 32'h0);
    check(32'(evt_irq), 32'h0);
    apb(1'b0, irq_level_pkg::ADDR_LEVEL_CTRL_HI, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, irq_level_pkg::ADDR_LEVEL_ENCODE, 32'h0);
    check(rd, 32'h0);
    pins(24'hFFFFFF);
    tally_and_finish();
  end
endmodule
